// >>> nhi_evt.sv
// nhi_evt: toggle-to-pulse event crossing
`timescale 1ns/1ps
module nhi_evt (
   // receiving clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // toggle from the far domain
   input  wire logic tgl,
   // one-cycle pulse for each toggle
   output logic      pulse
);
   logic tgl_s;
   logic tgl_q;

   nhi_sync #(
      .W (1)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   (tgl),
      .q   (tgl_s)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tgl_q <= 1'b0;
         pulse <= 1'b0;
      end else begin
         tgl_q <= tgl_s;
         pulse <= tgl_s ^ tgl_q;
      end
   end

endmodule : nhi_evt

// >>> nhi_host_model.sv
// nhi_host_model: behavioural bus controller facing the target port
`timescale 1ns/1ps
module nhi_host_model #(
   parameter int HI_NS  = 6,
   parameter int LO_NS  = 6,
   parameter int GAP_NS = 60
) (
   // resolved wire levels
   input  wire logic scl,
   input  wire logic sda,
   // open-drain pulls, high = drive low
   output logic      scl_oe,
   output logic      sda_oe
);
   int stuck = 0;
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // ==========================================
   // bit timing
   // honour clock stretch
   task automatic rise;
      int k;
      scl_oe = 1'b0;
      k = 0;
      while (scl !== 1'b1 && k < 4000) begin
         #1;
         k++;
      end
      if (scl !== 1'b1) stuck++;
   endtask : rise
   task automatic bit_cyc(input logic pull, input int lo, output logic s);
      scl_oe = 1'b1;
      #2 sda_oe = pull;
      #(lo - 2);
      rise();
      #(HI_NS / 2) s = sda;
      #(HI_NS - HI_NS / 2);
   endtask : bit_cyc
   // ==========================================
   // framing
   // start: data pulled low while the clock is high
   task automatic start;
      #40 sda_oe = 1'b1;
      #40;
   endtask : start
   task automatic stop;
      scl_oe = 1'b1;
      #2 sda_oe = 1'b1;
      #(GAP_NS);
      rise();
      #40 sda_oe = 1'b0;
      #60;
   endtask : stop
   // long low phases around the acknowledge leave room for the core
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(~b[i], i == 7 ? GAP_NS : LO_NS, s);
      bit_cyc(1'b0, GAP_NS, ack);
   endtask : wr_byte
   task automatic rd_byte(output logic [7:0] b, input logic nack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b0, i == 7 ? GAP_NS : LO_NS, s);
         b[i] = s;
      end
      bit_cyc(~nack, GAP_NS, s);
   endtask : rd_byte
endmodule : nhi_host_model

// >>> nhi_pkg.sv
// nhi_pkg: constants and types of the host serial target port
package nhi_pkg;

   // ==========================================================
   // clock rates
   localparam int unsigned CORE_CLK_HZ  = 250_000_000;
   localparam int unsigned SCL_STD_HZ   = 100_000;
   localparam int unsigned SCL_FAST_HZ  = 400_000;
   localparam int unsigned SCL_HS_HZ    = 3_400_000;
   // core cycles in one high-speed serial clock period
   localparam int unsigned SCL_HS_PERIOD_CYC = CORE_CLK_HZ / SCL_HS_HZ;
   // worst core reaction to a pin edge: two sync stages and one decode
   localparam int unsigned SYNC_LAT_CYC = 3;

   // ==========================================================
   // frame layout
   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned ADDR_W     = 7;
   localparam logic [4:0]  ADDR_FIXED = 5'h0A;
   localparam logic [3:0]  BIT_FIRST  = 4'h0;
   localparam logic [3:0]  BIT_ACK    = 4'h8;
   localparam logic [2:0]  BIT_MSB    = 3'h7;
   localparam logic [7:0]  GEN_CALL   = 8'h00;

   // ==========================================================
   // values after reset
   localparam logic [6:0]  ADDR_RST   = {ADDR_FIXED, 2'h0};
   localparam logic [7:0]  BYTE_RST   = 8'h00;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      NHI_MODE_IDLE   = 2'b00,
      NHI_MODE_LISTEN = 2'b01,
      NHI_MODE_POLL   = 2'b10
   } nhi_mode_t;

   typedef enum logic {
      NHI_PWR_STANDBY = 1'b0,
      NHI_PWR_ACTIVE  = 1'b1
   } nhi_pwr_t;

endpackage : nhi_pkg

// >>> nhi_sync.sv
// nhi_sync: two-flop level synchroniser
`timescale 1ns/1ps
module nhi_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : nhi_sync

// >>> nhi_target_port.sv
// nhi_target_port: host serial target port with wake and interrupt
`timescale 1ns/1ps
module nhi_target_port (
   // core clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   // serial clock pin, also the link clock
   input  wire logic                      host_serial_clock_pin_in,
   output logic                           host_serial_clock_pin_out,
   output logic                           host_serial_clock_pin_oe,
   // serial data pin
   input  wire logic                      host_serial_data_pin_in,
   output logic                           host_serial_data_pin_out,
   output logic                           host_serial_data_pin_oe,
   // address straps
   input  wire logic                      addr_strap_bit0,
   input  wire logic                      addr_strap_bit1,
   // static configuration
   input  wire logic                      if_sel_i2c,
   input  wire logic                      irq_active_high,
   // interrupt to host
   output logic                           irq_pin,
   // power and functional mode
   input  wire nhi_pkg::nhi_mode_t        func_mode,
   input  wire logic                      standby_req,
   output logic                           power_active,
   output logic                           rf_enable,
   output logic                           wake,
   // bytes written by the host
   output logic [nhi_pkg::BYTE_W-1:0]     rx_data,
   output logic                           rx_valid,
   input  wire logic                      rx_ready,
   // bytes read by the host
   input  wire logic [nhi_pkg::BYTE_W-1:0] tx_data,
   input  wire logic                      tx_last,
   input  wire logic                      tx_valid,
   output logic                           tx_ready,
   // a message is waiting for the host
   input  wire logic                      msg_post
);
   import nhi_pkg::*;

   // ==========================================================
   // pin synchronisers
   logic [3:0]        pin_s;
   logic              scl_s;
   logic              sda_s;
   logic              scl_q;
   logic              sda_q;
   logic              start_cond;
   logic              stop_cond;
   logic              bus_busy;
   logic              frame_rst;
   logic [ADDR_W-1:0] own_addr;

   nhi_sync #(
      .W (4)
   ) u_pin_sync (
      .clk (core_clk),
      .rst (rst),
      .d   ({host_serial_clock_pin_in, host_serial_data_pin_in,
             addr_strap_bit1, addr_strap_bit0}),
      .q   (pin_s)
   );

   assign scl_s = pin_s[3];
   assign sda_s = pin_s[2];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   assign start_cond = scl_q & scl_s & sda_q & ~sda_s;
   assign stop_cond  = scl_q & scl_s & ~sda_q & sda_s;

   // ==========================================================
   // frame control
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus_busy <= 1'b0;
      end else if (!if_sel_i2c || stop_cond) begin
         bus_busy <= 1'b0;
      end else if (start_cond) begin
         bus_busy <= 1'b1;
      end
   end

   // pins idle unless selected
   // the link logic is held in reset between frames and pulsed at each
   // start; release lands while the clock is still high
   // release fits a fast clock high phase
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         frame_rst <= 1'b1;
      end else begin
         frame_rst <= ~if_sel_i2c | start_cond | ~bus_busy;
      end
   end

   // strap-built own address
   // straps are caught only between frames, so the link sees a still value
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         own_addr <= ADDR_RST;
      end else if (frame_rst) begin
         own_addr <= {ADDR_FIXED, pin_s[1:0]};
      end
   end

   // ==========================================================
   // link domain: shifting on the serial clock
   logic [BYTE_W-1:0] shreg;
   logic [3:0]        bit_cnt;
   logic              first_byte;
   logic              after9;
   logic              ack_ok;
   logic              addr_hit;
   logic              matched;
   logic              reading;
   logic              sending;
   logic              sda_drv;
   logic [BYTE_W-1:0] tx_sr;
   logic [BYTE_W-1:0] tx_hold;
   logic              tgl_wr;
   logic              tgl_rd;
   logic              tgl_rx;
   logic              tgl_tx;

   // fixed upper bits reject general call and 10-bit
   assign addr_hit = (shreg[BYTE_W-1:1] == own_addr);

   always_ff @(posedge host_serial_clock_pin_in or posedge frame_rst) begin
      if (frame_rst) begin
         shreg      <= BYTE_RST;
         bit_cnt    <= BIT_FIRST;
         first_byte <= 1'b1;
         after9     <= 1'b0;
         ack_ok     <= 1'b0;
      end else if (bit_cnt == BIT_ACK) begin
         bit_cnt    <= BIT_FIRST;
         first_byte <= 1'b0;
         after9     <= 1'b1;
         ack_ok     <= first_byte | ~host_serial_data_pin_in;
      end else begin
         shreg      <= {shreg[BYTE_W-2:0], host_serial_data_pin_in};
         bit_cnt    <= bit_cnt + 4'h1;
         after9     <= 1'b0;
      end
   end

   // bit timing on the falling edge
   // tx_hold is sampled here only after the core has let the clock go,
   // so the stretch itself is the handshake for that word
   always_ff @(negedge host_serial_clock_pin_in or posedge frame_rst) begin
      if (frame_rst) begin
         matched <= 1'b0;
         reading <= 1'b0;
         sending <= 1'b0;
         sda_drv <= 1'b0;
         tx_sr   <= BYTE_RST;
      end else if (bit_cnt == BIT_ACK) begin
         sending <= 1'b0;
         if (first_byte) begin
            matched <= addr_hit;
            reading <= shreg[0];
            sda_drv <= addr_hit;
         end else begin
            sda_drv <= matched & ~reading;
         end
      end else if (after9) begin
         if (matched && reading && ack_ok) begin
            tx_sr   <= tx_hold;
            sending <= 1'b1;
            sda_drv <= ~tx_hold[BYTE_W-1];
         end else begin
            sending <= 1'b0;
            sda_drv <= 1'b0;
         end
      end else if (sending) begin
         sda_drv <= ~tx_sr[BIT_MSB - bit_cnt[2:0]];
      end else begin
         sda_drv <= 1'b0;
      end
   end

   // event toggles only see the core reset: a frame reset must not
   // flip them and fake an event
   always_ff @(negedge host_serial_clock_pin_in or posedge rst) begin
      if (rst) begin
         tgl_wr <= 1'b0;
         tgl_rd <= 1'b0;
         tgl_rx <= 1'b0;
         tgl_tx <= 1'b0;
      end else begin
         if (bit_cnt == BIT_ACK && first_byte && addr_hit) begin
            tgl_wr <= tgl_wr ^ ~shreg[0];
            tgl_rd <= tgl_rd ^ shreg[0];
         end
         if (bit_cnt == BIT_ACK && !first_byte && matched && !reading) begin
            tgl_rx <= ~tgl_rx;
         end
         if (after9 && matched && reading && ack_ok) begin
            tgl_tx <= ~tgl_tx;
         end
      end
   end

   assign host_serial_data_pin_oe   = sda_drv;
   assign host_serial_data_pin_out  = 1'b0;
   assign host_serial_clock_pin_out = 1'b0;

   // ==========================================================
   // events into the core domain
   logic hit_wr_evt;
   logic hit_rd_evt;
   logic rx_evt;
   logic tx_evt;
   logic hit_evt;

   nhi_evt u_evt_wr (
      .clk   (core_clk),
      .rst   (rst),
      .tgl   (tgl_wr),
      .pulse (hit_wr_evt)
   );

   nhi_evt u_evt_rd (
      .clk   (core_clk),
      .rst   (rst),
      .tgl   (tgl_rd),
      .pulse (hit_rd_evt)
   );

   nhi_evt u_evt_rx (
      .clk   (core_clk),
      .rst   (rst),
      .tgl   (tgl_rx),
      .pulse (rx_evt)
   );

   nhi_evt u_evt_tx (
      .clk   (core_clk),
      .rst   (rst),
      .tgl   (tgl_tx),
      .pulse (tx_evt)
   );

   assign hit_evt = hit_wr_evt | hit_rd_evt;

   // ==========================================================
   // receive and transmit words
   logic tx_accept;
   logic tx_full;
   logic tx_hold_last;
   logic next_tx_full;
   logic want_tx;
   logic pending;

   // shreg stays still from the eighth rising edge to the next byte
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_data <= BYTE_RST;
      end else if (rx_evt) begin
         rx_data <= shreg;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_valid <= 1'b0;
      end else if (rx_evt) begin
         rx_valid <= 1'b1;
      end else if (rx_ready) begin
         rx_valid <= 1'b0;
      end
   end

   assign tx_accept = tx_valid & tx_ready;

   always_comb begin
      next_tx_full = tx_full;
      if (tx_accept) begin
         next_tx_full = 1'b1;
      end else if (tx_evt) begin
         next_tx_full = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_hold      <= BYTE_RST;
         tx_hold_last <= 1'b0;
         tx_full      <= 1'b0;
         tx_ready     <= 1'b1;
      end else begin
         if (tx_accept) begin
            tx_hold      <= tx_data;
            tx_hold_last <= tx_last;
         end
         tx_full  <= next_tx_full;
         tx_ready <= ~next_tx_full;
      end
   end

   // no stretch after the last byte, so a closing not-acknowledge and
   // stop are never held up
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         want_tx <= 1'b0;
      end else if (frame_rst) begin
         want_tx <= 1'b0;
      end else if (hit_rd_evt) begin
         want_tx <= 1'b1;
      end else if (tx_evt) begin
         want_tx <= ~tx_hold_last;
      end
   end

   // hold clock low for flow control
   // engaging only while the pin reads low keeps most edges clean; a
   // controller that rises within the sync delay may see a short pulse
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         host_serial_clock_pin_oe <= 1'b0;
      end else begin
         host_serial_clock_pin_oe <= if_sel_i2c & bus_busy & ~scl_s &
                                     (rx_valid | (want_tx & ~tx_full));
      end
   end

   // ==========================================================
   // interrupt
   // pending until last byte taken for sending
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pending <= 1'b0;
      end else if (msg_post) begin
         pending <= 1'b1;
      end else if (tx_evt && tx_hold_last) begin
         pending <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_pin <= 1'b0;
      end else begin
         irq_pin <= pending ? irq_active_high : ~irq_active_high;
      end
   end

   // ==========================================================
   // power state and radio enable
   nhi_pwr_t pwr;
   nhi_pwr_t next_pwr;
   logic     next_rf;

   always_comb begin
      next_pwr = pwr;
      unique case (pwr)
         NHI_PWR_STANDBY: begin
            if (hit_evt) begin
               next_pwr = NHI_PWR_ACTIVE;
            end
         end
         NHI_PWR_ACTIVE: begin
            if (standby_req) begin
               next_pwr = NHI_PWR_STANDBY;
            end
         end
      endcase
   end

   always_comb begin
      next_rf = 1'b0;
      unique case (func_mode)
         NHI_MODE_IDLE:   next_rf = 1'b0;
         NHI_MODE_LISTEN: next_rf = (next_pwr == NHI_PWR_ACTIVE);
         NHI_MODE_POLL:   next_rf = (next_pwr == NHI_PWR_ACTIVE);
         default:         next_rf = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pwr          <= NHI_PWR_ACTIVE;
         power_active <= 1'b1;
         wake         <= 1'b0;
         rf_enable    <= 1'b0;
      end else begin
         pwr          <= next_pwr;
         power_active <= (next_pwr == NHI_PWR_ACTIVE);
         wake         <= (pwr == NHI_PWR_STANDBY) & hit_evt;
         rf_enable    <= next_rf;
      end
   end

   // ==========================================================
   // checks
   sequence s_own_addr_seen;
      hit_wr_evt || hit_rd_evt;
   endsequence

   property p_wake_own;
      @(posedge core_clk) disable iff (rst)
      (pwr == NHI_PWR_STANDBY) ##0 s_own_addr_seen |=> wake && power_active;
   endproperty
   a_wake_own: assert property (p_wake_own)
      else $error("no wake after own address");

   property p_no_stray_wake;
      @(posedge core_clk) disable iff (rst)
      !(hit_wr_evt || hit_rd_evt) |=> !wake;
   endproperty
   a_no_stray_wake: assert property (p_no_stray_wake)
      else $error("wake without own address");

   property p_rf_idle;
      @(posedge core_clk) disable iff (rst)
      !power_active || ($past(func_mode) == NHI_MODE_IDLE) |-> !rf_enable;
   endproperty
   a_rf_idle: assert property (p_rf_idle)
      else $error("radio on in idle or standby");

   property p_irq_set;
      @(posedge core_clk) disable iff (rst)
      msg_post |=> ##1 (irq_pin == irq_active_high);
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("interrupt not at active level");

   property p_irq_clr;
      @(posedge core_clk) disable iff (rst)
      tx_evt && tx_hold_last && !msg_post |=> !msg_post |->
         ##1 (irq_pin != irq_active_high);
   endproperty
   a_irq_clr: assert property (p_irq_clr)
      else $error("interrupt kept after message read");

   property p_stretch;
      @(posedge core_clk) disable iff (rst)
      if_sel_i2c && bus_busy && !scl_s && rx_valid |=> host_serial_clock_pin_oe;
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("clock not held with byte waiting");

   property p_unsel;
      @(posedge core_clk) disable iff (rst)
      !if_sel_i2c |=> frame_rst && !host_serial_clock_pin_oe;
   endproperty
   a_unsel: assert property (p_unsel)
      else $error("port active while not selected");

   property p_rx_capture;
      @(posedge core_clk) disable iff (rst)
      rx_evt |=> rx_valid && (rx_data == $past(shreg));
   endproperty
   a_rx_capture: assert property (p_rx_capture)
      else $error("received byte not presented");

   property p_ack_own;
      @(posedge host_serial_clock_pin_in) disable iff (frame_rst)
      (bit_cnt == BIT_ACK) && first_byte |->
         (host_serial_data_pin_oe == (shreg[BYTE_W-1:1] == own_addr));
   endproperty
   a_ack_own: assert property (p_ack_own)
      else $error("address acknowledge wrong");

   property p_no_gen_call;
      @(posedge host_serial_clock_pin_in) disable iff (frame_rst)
      (bit_cnt == BIT_ACK) && first_byte && (shreg == GEN_CALL) |->
         !host_serial_data_pin_oe ##1 !reading;
   endproperty
   a_no_gen_call: assert property (p_no_gen_call)
      else $error("general call acknowledged");

   property p_hs_margin;
      @(posedge core_clk) disable iff (rst)
      $fell(frame_rst) |-> scl_s && scl_q;
   endproperty
   a_hs_margin: assert property (p_hs_margin)
      else $error("link released with clock low");

endmodule : nhi_target_port

// >>> tb_nhi_target_port.sv
// tb_nhi_target_port: scenario bench for the host serial target port
`timescale 1ns/1ps
module tb_nhi_target_port;
   import nhi_pkg::*;
   // ==========================================
   // signals
   logic       core_clk = 1'b0, rst = 1'b0, h_scl_oe, h_sda_oe;
   logic       scl, sda, scl_oe, sda_oe, irq_pin, power_active, wake;
   logic       rf_enable, rx_valid, tx_ready;
   logic [7:0] rx_data, last_rx, own_w = 8'h56;
   logic       addr_strap_bit0 = 1'b0, addr_strap_bit1 = 1'b0;
   logic       if_sel_i2c = 1'b1, irq_active_high = 1'b1, standby_req = 1'b0;
   logic       rx_ready = 1'b1, tx_last = 1'b0, tx_valid = 1'b0;
   logic       msg_post = 1'b0, stretch_seen = 1'b0, any_oe = 1'b0, a, b;
   logic [7:0] tx_data = 8'h00;
   nhi_mode_t  func_mode = NHI_MODE_IDLE;
   int         fails = 0, n_tests = 0, wake_cnt = 0;
   assign scl = ~(h_scl_oe | scl_oe);
   assign sda = ~(h_sda_oe | sda_oe);
   initial forever #2 core_clk = ~core_clk;
   nhi_target_port u_dut (.core_clk, .rst,
      .host_serial_clock_pin_in(scl), .host_serial_clock_pin_out(),
      .host_serial_clock_pin_oe(scl_oe), .host_serial_data_pin_in(sda),
      .host_serial_data_pin_out(), .host_serial_data_pin_oe(sda_oe),
      .addr_strap_bit0, .addr_strap_bit1, .if_sel_i2c, .irq_active_high,
      .irq_pin, .func_mode, .standby_req, .power_active, .rf_enable, .wake,
      .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_last, .tx_valid,
      .tx_ready, .msg_post);
   nhi_host_model u_host (.scl(scl), .sda(sda), .scl_oe(h_scl_oe),
      .sda_oe(h_sda_oe));
   // ==========================================
   // monitors
   always @(posedge core_clk) begin
      if (wake === 1'b1) wake_cnt++;
      if (scl_oe === 1'b1) stretch_seen = 1'b1;
      if (scl_oe === 1'b1 || sda_oe === 1'b1) any_oe = 1'b1;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) last_rx = rx_data;
   end
   // ==========================================
   // helpers
   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic finish_test;
      if (fails == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc
   task automatic xfer(input logic [7:0] ad, output logic ack);
      u_host.start();
      u_host.wr_byte(ad, ack);
      u_host.stop();
   endtask : xfer
   task automatic feed(input logic [7:0] d, input logic l);
      int k;
      @(negedge core_clk);
      tx_data = d;
      tx_last = l;
      tx_valid = 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (tx_ready !== 1'b1 && k < 2000);
      @(negedge core_clk);
      tx_valid = 1'b0;
      check("tx taken", 8'(k < 2000), 8'h01);
   endtask : feed
   // ==========================================
   // scenarios
   task automatic t_reset;
      cyc(2);
      check("power_active", power_active, 1'b1);
      check("irq idle", irq_pin, 1'b0);
      check("tx_ready", tx_ready, 1'b1);
      check("pins free", {scl_oe, sda_oe, rx_valid}, 8'h00);
   endtask : t_reset
   task automatic t_addr;
      logic [7:0] own, rej [2];
      rej = '{8'h00, 8'hF0};
      for (int s = 0; s < 4; s++) begin
         @(negedge core_clk);
         addr_strap_bit0 = s[0];
         addr_strap_bit1 = s[1];
         cyc(6);
         own = 8'h50 + 8'(2 * s);
         u_host.start();
         u_host.wr_byte(own, a);
         u_host.wr_byte(8'h30 + 8'(s), b);
         u_host.stop();
         check("own addr ack", {a, b}, 8'h00);
         check("rx byte", last_rx, 8'h30 + 8'(s));
         xfer(own ^ 8'h02, a);
         check("other addr", a, 1'b1);
      end
      for (int i = 0; i < 2; i++) begin
         xfer(rej[i], a);
         check("gen call or 10 bit", a, 1'b1);
      end
   endtask : t_addr
   task automatic t_modes;
      nhi_mode_t m [3];
      m = '{NHI_MODE_IDLE, NHI_MODE_LISTEN, NHI_MODE_POLL};
      for (int i = 0; i < 3; i++) begin
         @(negedge core_clk);
         func_mode = m[i];
         cyc(2);
         check("rf_enable", rf_enable, m[i] != NHI_MODE_IDLE);
      end
   endtask : t_modes
   task automatic t_stretch;
      @(negedge core_clk);
      rx_ready = 1'b0;
      stretch_seen = 1'b0;
      u_host.start();
      u_host.wr_byte(own_w, a);
      fork
         begin
            u_host.wr_byte(8'h11, a);
            u_host.wr_byte(8'h22, b);
         end
         begin
            #400;
            @(negedge core_clk);
            rx_ready = 1'b1;
         end
      join
      u_host.stop();
      check("stretched write ack", {a, b}, 8'h00);
      check("stretch seen", stretch_seen, 1'b1);
      check("last rx", last_rx, 8'h22);
   endtask : t_stretch
   task automatic t_read;
      logic [7:0] b0, b1;
      for (int p = 0; p < 2; p++) begin
         @(negedge core_clk);
         irq_active_high = p[0];
         stretch_seen = 1'b0;
         cyc(3);
         check("irq inactive", irq_pin, !p[0]);
         msg_post = 1'b1;
         @(negedge core_clk);
         msg_post = 1'b0;
         cyc(2);
         check("irq pending", irq_pin, p[0]);
         u_host.start();
         fork
            begin
               #300;
               feed(8'hA5, 1'b0);
               feed(8'h3C, 1'b1);
            end
            begin
               u_host.wr_byte(own_w | 8'h01, a);
               u_host.rd_byte(b0, 1'b0);
               u_host.rd_byte(b1, 1'b1);
            end
         join
         u_host.stop();
         check("read ack", a, 1'b0);
         check("read b0", b0, 8'hA5);
         check("read b1", b1, 8'h3C);
         check("read stretch", stretch_seen, 1'b1);
         check("irq cleared", irq_pin, !p[0]);
      end
   endtask : t_read
   task automatic t_wake;
      @(negedge core_clk);
      standby_req = 1'b1;
      @(negedge core_clk);
      standby_req = 1'b0;
      cyc(1);
      check("standby", {power_active, rf_enable}, 8'h00);
      xfer(own_w ^ 8'h04, a);
      cyc(8);
      check("no wake", 8'(wake_cnt), 8'h00);
      check("still standby", power_active, 1'b0);
      xfer(own_w, a);
      cyc(8);
      check("wake pulse", 8'(wake_cnt), 8'h01);
      check("active again", {power_active, rf_enable}, 8'h03);
   endtask : t_wake
   task automatic t_unsel;
      @(negedge core_clk);
      if_sel_i2c = 1'b0;
      cyc(4);
      any_oe = 1'b0;
      xfer(own_w, a);
      check("unselected nack", a, 1'b1);
      check("unselected pins", any_oe, 1'b0);
      @(negedge core_clk);
      if_sel_i2c = 1'b1;
      cyc(4);
      xfer(own_w, a);
      check("selected ack", a, 1'b0);
   endtask : t_unsel
   // ==========================================
   // main sequence and watchdog
   initial begin
      // a real rising edge, so flops clocked by the link reset as well
      #1 rst = 1'b1;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      t_reset();
      t_addr();
      t_modes();
      t_stretch();
      t_read();
      t_wake();
      t_unsel();
      check("host stuck", 8'(u_host.stuck), 8'h00);
      finish_test();
   end
   initial begin
      #100000;
      fails++;
      finish_test();
   end
endmodule : tb_nhi_target_port
